/* File: rtl/bus_and_chip_select_config.sv */
// Bus configuration and chip select enable registers with pin function steering
//
// Behaviour
// - External bus select low leaves ports 0 to 2 as I/O, high makes them the address and data bus.
// - In test mode an access to on-chip memory or I/O also drives its data onto the external data bus.
// - With test mode off the run pin carries the ordinary run status.
// - The lower port 5 edge enable makes pins 0 to 3 of port 5 edge interrupt inputs.
// - The port 4 edge enable makes pins 4 to 7 of port 4 edge interrupt inputs.
// - Each chip select enable bit turns its active-low select output on or off, except bit seven while the rom source bit is set.
// - With select one active, 0100 to 011F leaves selects three and six and goes to select one.
// - With select two active, 0120 to 013F leaves selects three and six and goes to select two.
// - Select seven is enabled whenever the rom source bit is set.
// - Stack goes to internal RAM unless select three or six is enabled.
// - A strap rising after reset release sets rom source, test mode and external bus bits.
// - A strap already high before reset release leaves the bus configuration all zero.
// - Once the strap window closes the strap has no further effect and software owns the register.
// - Rom source picks internal or external ROM, the strap picks external or internal processor.
`timescale 1ns/1ps
`include "bus_and_chip_select_config_cfg.svh"

module bus_and_chip_select_config
   import bus_and_chip_select_config_pkg::*;
(
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Device pins
   input wire logic reset_in_n,
   input wire logic bus_enable_strap,
   // CPU access
   input wire logic cpu_access,
   input wire logic cpu_internal,
   input wire logic cpu_stack,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_data,
   input wire logic cpu_run,
   // Chip selects
   output logic [7:0] select_line_n,
   output logic stack_off_chip,
   // Test mode data echo and run pin
   output logic [7:0] ext_data_out,
   output logic ext_data_oe,
   output logic run_pin_out,
   // Pin function selects
   output logic port012_ext_bus,
   output logic test_mode_active,
   output logic rom_external,
   output logic processor_external,
   output logic [3:0] port5_lo_edge_fn,
   output logic [3:0] port5_hi_edge_fn,
   output logic [3:0] port4_edge_fn,
   output logic port4_irq_pin_fn,
   output logic serial_network_fn,
   output logic serial_network_irq_en
);

   cfg_state_t q;
   cfg_state_t d;

   localparam logic [127:0] CS_LO = `CS_LO_TABLE;
   localparam logic [127:0] CS_HI = `CS_HI_TABLE;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
      reg_hit = (adr[7:2] == idx);
   endfunction

   logic [7:0] window_hit;
   logic [7:0] cs_en_eff;
   logic carve_one;
   logic carve_two;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_win
         assign window_hit[gi] = in_range(cpu_addr, CS_LO[gi*16 +: 16], CS_HI[gi*16 +: 16]);
      end
   endgenerate

   always_comb
   begin
      cs_en_eff = q.cs_en;
      cs_en_eff[`CSF_SEVEN] = q.cs_en[`CSF_SEVEN] | q.bus_cfg[`BCF_ROM_SRC];
      carve_one = cs_en_eff[`CSF_ONE] & in_range(cpu_addr, `CARVE_ONE_LO, `CARVE_ONE_HI);
      carve_two = cs_en_eff[`CSF_TWO] & in_range(cpu_addr, `CARVE_TWO_LO, `CARVE_TWO_HI);
   end

   logic wb_req;
   logic wb_wr;
   logic [7:0] sel_hit;

   assign wb_req = wb_cyc_i & wb_stb_i & ~q.ack;
   assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

   always_comb
   begin
      d = q;
      // The second stage feeds logic and the third only the strap edge detect; the first is metastability settling
      d.rst_s1 = reset_in_n;
      d.rst_s2 = q.rst_s1;
      d.rst_s3 = q.rst_s2;
      d.strap_s1 = bus_enable_strap;
      d.strap_s2 = q.strap_s1;
      d.strap_s3 = q.strap_s2;

      // Software writes land first so a strap event in the same cycle wins
      if (wb_wr && reg_hit(wb_adr_i, `IDX_CHIP_SELECT_ENABLE))
      begin
         d.cs_en = wb_dat_i[7:0];
      end
      if (wb_wr && reg_hit(wb_adr_i, `IDX_BUS_CONFIGURATION))
      begin
         d.bus_cfg = wb_dat_i[7:0];
      end

      case (q.strap_st)
         ST_HELD:
         begin
            d.bus_cfg = `RST_BUS_CONFIGURATION;
            d.cs_en = `RST_CHIP_SELECT_ENABLE;
            if (q.strap_s2)
            begin
               d.strap_before = 1'b1;
            end
            if (q.rst_s2)
            begin
               d.proc_internal = q.strap_s2;
               // Strap seen before release keeps the register cleared
               d.strap_st = (q.strap_before | q.strap_s2) ? ST_SETTLED : ST_ARMED;
            end
         end
         ST_ARMED:
         begin
            if (q.strap_s2 && !q.strap_s3)
            begin
               d.bus_cfg = d.bus_cfg | `STRAP_SET_MASK;
               d.strap_st = ST_SETTLED;
            end
            else if (wb_wr && reg_hit(wb_adr_i, `IDX_BUS_CONFIGURATION))
            begin
               // A software write to the bus configuration closes the strap window
               d.strap_st = ST_SETTLED;
            end
         end
         ST_SETTLED:
         begin
            d.strap_st = ST_SETTLED;
         end
         default:
         begin
            d.strap_st = ST_HELD;
         end
      endcase

      if (!q.rst_s2)
      begin
         d.strap_st = ST_HELD;
         d.bus_cfg = `RST_BUS_CONFIGURATION;
         d.cs_en = `RST_CHIP_SELECT_ENABLE;
         if (q.strap_st != ST_HELD)
         begin
            d.strap_before = 1'b0;
         end
      end

      // Wishbone answer one cycle after the request, unmapped reads give zero
      d.ack = wb_req;
      d.rdata = '0;
      if (wb_req && !wb_we_i)
      begin
         if (reg_hit(wb_adr_i, `IDX_CHIP_SELECT_ENABLE))
         begin
            d.rdata[7:0] = q.cs_en;
         end
         else if (reg_hit(wb_adr_i, `IDX_BUS_CONFIGURATION))
         begin
            d.rdata[7:0] = q.bus_cfg;
         end
         else if (reg_hit(wb_adr_i, `IDX_CONFIG_STATUS))
         begin
            d.rdata[7:0] = {cs_en_eff[`CSF_SEVEN], q.stack_off_chip, q.proc_internal,
                            q.strap_before, q.strap_s2, q.strap_st};
         end
      end

      // Chip selects decode, carved windows taken from selects three and six
      sel_hit = window_hit;
      sel_hit[`CSF_ONE] = window_hit[`CSF_ONE] | carve_one;
      sel_hit[`CSF_TWO] = window_hit[`CSF_TWO] | carve_two;
      if (carve_one || carve_two)
      begin
         sel_hit[`CSF_THREE] = 1'b0;
         sel_hit[`CSF_SIX] = 1'b0;
      end
      d.cs_n = ~(sel_hit & cs_en_eff & {8{cpu_access & ~cpu_internal}});

      d.stack_off_chip = cs_en_eff[`CSF_THREE] | cs_en_eff[`CSF_SIX];
      if (cpu_stack && !d.stack_off_chip)
      begin
         // Stack stays on chip, keep every select idle
         d.cs_n = '1;
      end

      // Test mode echoes on-chip traffic onto the external data bus
      d.ext_oe = q.bus_cfg[`BCF_TEST_MODE] & cpu_access & cpu_internal;
      d.ext_data = cpu_data;
      if (q.bus_cfg[`BCF_TEST_MODE])
      begin
         d.run_pin = cpu_access & cpu_internal;
      end
      else
      begin
         d.run_pin = cpu_run;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         q.rst_s1 <= 1'b0;
         q.rst_s2 <= 1'b0;
         q.rst_s3 <= 1'b0;
         q.strap_s1 <= 1'b0;
         q.strap_s2 <= 1'b0;
         q.strap_s3 <= 1'b0;
         q.strap_before <= 1'b0;
         q.proc_internal <= 1'b0;
         q.strap_st <= ST_HELD;
         q.bus_cfg <= `RST_BUS_CONFIGURATION;
         q.cs_en <= `RST_CHIP_SELECT_ENABLE;
         q.ack <= 1'b0;
         q.rdata <= '0;
         q.cs_n <= '1;
         q.ext_data <= '0;
         q.ext_oe <= 1'b0;
         q.run_pin <= 1'b0;
         q.stack_off_chip <= 1'b0;
      end
      else if (clk_en)
      begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdata;
   assign select_line_n = q.cs_n;
   assign stack_off_chip = q.stack_off_chip;
   assign ext_data_out = q.ext_data;
   assign ext_data_oe = q.ext_oe;
   assign run_pin_out = q.run_pin;

   assign port012_ext_bus = q.bus_cfg[`BCF_EXT_BUS];
   assign test_mode_active = q.bus_cfg[`BCF_TEST_MODE];
   assign rom_external = q.bus_cfg[`BCF_ROM_SRC];
   assign processor_external = ~q.proc_internal;
   assign port5_lo_edge_fn = {4{q.bus_cfg[`BCF_P5_LO_EDGE]}};
   assign port5_hi_edge_fn = {4{q.bus_cfg[`BCF_P5_HI_EDGE]}};
   assign port4_edge_fn = {4{q.bus_cfg[`BCF_PORT4_EDGE]}};
   assign port4_irq_pin_fn = q.bus_cfg[`BCF_IRQ_PINS];
   assign serial_network_fn = q.bus_cfg[`BCF_SERIAL_NET];
   assign serial_network_irq_en = q.bus_cfg[`BCF_SERIAL_NET];

endmodule

/* File: rtl/bus_and_chip_select_config_cfg.svh */
// Offsets, field positions, reset values and decode windows of the configuration block
`ifndef BUS_AND_CHIP_SELECT_CONFIG_CFG_SVH
`define BUS_AND_CHIP_SELECT_CONFIG_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_CHIP_SELECT_ENABLE 6'h07
`define IDX_BUS_CONFIGURATION 6'h1B
`define IDX_CONFIG_STATUS 6'h20
`define RST_CHIP_SELECT_ENABLE 8'h00
`define RST_BUS_CONFIGURATION 8'h00
// Bus configuration field positions
`define BCF_EXT_BUS 0
`define BCF_PORT4_EDGE 1
`define BCF_SERIAL_NET 2
`define BCF_TEST_MODE 3
`define BCF_P5_LO_EDGE 4
`define BCF_P5_HI_EDGE 5
`define BCF_IRQ_PINS 6
`define BCF_ROM_SRC 7
// Bits forced by a late strap: rom source, test mode, external bus
`define STRAP_SET_MASK 8'h89
// Chip select field positions
`define CSF_ONE 1
`define CSF_TWO 2
`define CSF_THREE 3
`define CSF_SIX 6
`define CSF_SEVEN 7
// Decode windows, select 7 in the top slice
`define CS_LO_TABLE {16'hF000, 16'h0200, 16'hE800, 16'hE000, 16'h0100, 16'hC000, 16'hA000, 16'h8000}
`define CS_HI_TABLE {16'hFFFF, 16'h7FFF, 16'hEFFF, 16'hE7FF, 16'h01FF, 16'hDFFF, 16'hBFFF, 16'h9FFF}
`define CARVE_ONE_LO 16'h0100
`define CARVE_ONE_HI 16'h011F
`define CARVE_TWO_LO 16'h0120
`define CARVE_TWO_HI 16'h013F
`endif

/* File: rtl/bus_and_chip_select_config_pkg.sv */
// Types for the bus and chip select configuration block
package bus_and_chip_select_config_pkg;
   typedef enum logic [2:0] {
      ST_HELD = 3'b001,
      ST_ARMED = 3'b010,
      ST_SETTLED = 3'b100
   } strap_state_t;
   typedef struct packed {
      logic rst_s1;
      logic rst_s2;
      logic rst_s3;
      logic strap_s1;
      logic strap_s2;
      logic strap_s3;
      logic strap_before;
      logic proc_internal;
      strap_state_t strap_st;
      logic [7:0] bus_cfg;
      logic [7:0] cs_en;
      logic ack;
      logic [31:0] rdata;
      logic [7:0] cs_n;
      logic [7:0] ext_data;
      logic ext_oe;
      logic run_pin;
      logic stack_off_chip;
   } cfg_state_t;
endpackage

/* File: dv/cfg_checker_assertions.sv */
// Bus handshake and pin relation checks for the configuration block
`timescale 1ns/1ps
module cfg_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // CPU side
   input wire logic cpu_access,
   input wire logic cpu_internal,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0] cpu_data,
   input wire logic cpu_run,
   input wire logic [7:0] select_line_n,
   input wire logic [7:0] ext_data_out,
   input wire logic ext_data_oe,
   input wire logic run_pin_out,
   input wire logic test_mode_active
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_answer: assert property (clk_en && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
   a_echo_data: assert property (clk_en && test_mode_active && cpu_access && cpu_internal
      |=> ext_data_oe && ext_data_out == $past(cpu_data)) else $error("no echo");
   a_run_normal: assert property (clk_en && !test_mode_active
      |=> run_pin_out == $past(cpu_run)) else $error("run pin wrong");
   a_idle_quiet: assert property (clk_en && !(cpu_access && !cpu_internal)
      |=> select_line_n == 8'hFF) else $error("select while idle");
   a_one_select: assert property ($onehot0(~select_line_n)) else $error("two selects");
   a_carve_one: assert property (!select_line_n[1]
      |-> $past(cpu_addr) inside {[16'hA000:16'hBFFF], [16'h0100:16'h011F]}) else $error("select one range");
   a_carve_two: assert property (!select_line_n[2]
      |-> $past(cpu_addr) inside {[16'hC000:16'hDFFF], [16'h0120:16'h013F]}) else $error("select two range");
   cover property (ext_data_oe);
   cover property (select_line_n == 8'hFD);
   cover property (!select_line_n[7]);
endmodule
bind bus_and_chip_select_config cfg_checker chk (.*);

/* File: dv/ext_select_model.sv */
// External device model reporting which chip select pulls its line low
`timescale 1ns/1ps
module ext_select_model (
   // Chip select lines
   input wire logic [7:0] select_line_n,
   // Selected device as 8 plus its number, 0 when none
   output logic [3:0] hit
);
   always_comb
   begin
      hit = 4'h0;
      for (int k = 0; k < 8; k++)
         if (!select_line_n[k])
            hit = 4'h8 + 4'(k);
   end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the bus and chip select configuration block
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 0, resetn = 0, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 0, cpu_data = 0, select_line_n, ext_data_out, v;
   logic [3:0] wb_sel_i = 4'hF, port5_lo_edge_fn, port5_hi_edge_fn, port4_edge_fn, hit;
   logic [31:0] wb_dat_i = 0, wb_dat_o, q[$];
   logic reset_in_n = 0, bus_enable_strap = 0, cpu_access = 0, cpu_internal = 0, cpu_stack = 0, cpu_run = 0;
   logic [15:0] cpu_addr = 0, win[8] = '{16'h8000, 16'hA000, 16'hC000, 16'h0180, 16'hE000, 16'hE800, 16'h0200, 16'hF000};
   logic wb_ack_o, stack_off_chip, ext_data_oe, run_pin_out, port012_ext_bus, test_mode_active, rom_external;
   logic processor_external, port4_irq_pin_fn, serial_network_fn, serial_network_irq_en;
   logic [17:0] fn;
   integer seed = 35886, n_errors = 0, n_tests = 0, i;
   assign fn = {rom_external, port4_irq_pin_fn, port5_hi_edge_fn, port5_lo_edge_fn, test_mode_active,
      serial_network_fn, serial_network_irq_en, port4_edge_fn, port012_ext_bus};
   always #2.5 ref_clk = ~ref_clk;
   bus_and_chip_select_config uut (.*);
   ext_select_model pm (.select_line_n(select_line_n), .hit(hit));
   task cmp(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task report_and_stop;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Request held until ack is sampled; the monitor takes read data at that same edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      for (n = 0; wb_ack_o !== 1'b1 && n < 20; n++)
         @(posedge ref_clk);
      if (n == 20)
      begin
         // A bus that never answers ends the run through the common verdict
         n_errors++;
         report_and_stop;
      end
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   // Selects answer one cycle late, so look in the middle of the following cycle
   task cpu(input logic ii, ss, input logic [15:0] a);
      @(posedge ref_clk);
      {cpu_access, cpu_internal, cpu_stack, cpu_addr} <= {1'b1, ii, ss, a};
      {cpu_data, cpu_run} <= 9'($random(seed));
      @(posedge ref_clk);
      cpu_access <= 1'b0;
      @(negedge ref_clk);
   endtask
   always @(posedge ref_clk)
      if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i)
         cmp(wb_dat_o, q.size() > 0 ? q.pop_front() : 32'hDEADBEEF);
   initial
   begin
      #60000;
      n_errors++;
      report_and_stop;
   end
   initial
   begin
      repeat (3) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset_in_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      bus_enable_strap <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h6C, 32'h89);
      rd(8'h1C, 32'h00);
      rd(8'h40, 32'h00);
      cmp(processor_external, 1'b1);
      cpu(1'b1, 1'b0, 16'h0040);
      cmp({ext_data_oe, ext_data_out, run_pin_out}, {1'b1, cpu_data, 1'b1});
      cpu(1'b0, 1'b0, 16'hF000);
      cmp(select_line_n, 8'h7F);
      $display("boot test done");
      for (i = 0; i < 6; i++)
      begin
         v = 8'($random(seed));
         wb(1'b1, 8'h6C, {24'h0, v});
         bus_enable_strap <= ~bus_enable_strap;
         rd(8'h6C, {24'h0, v});
         @(negedge ref_clk);
         cmp(fn, {v[7], v[6], {4{v[5]}}, {4{v[4]}}, v[3], v[2], v[2], {4{v[1]}}, v[0]});
      end
      wb(1'b1, 8'h6C, 32'h00);
      cpu(1'b1, 1'b0, 16'h0040);
      cmp({ext_data_oe, run_pin_out}, {1'b0, cpu_run});
      $display("config test done");
      for (i = 0; i < 8; i++)
      begin
         wb(1'b1, 8'h1C, 32'h1 << i);
         cpu(1'b0, 1'b0, win[i]);
         cmp({stack_off_chip, hit, select_line_n}, {i == 3 || i == 6, 4'(8 + i), ~(8'h01 << i)});
         wb(1'b1, 8'h1C, {24'h0, ~(8'h01 << i)});
         cpu(1'b0, 1'b0, win[i]);
         cmp({hit, select_line_n}, 12'h0FF);
      end
      wb(1'b1, 8'h1C, 32'h4A);
      cpu(1'b0, 1'b0, 16'h0100);
      cmp(select_line_n, 8'hFD);
      wb(1'b1, 8'h1C, 32'h4C);
      cpu(1'b0, 1'b0, 16'h013F);
      cmp(select_line_n, 8'hFB);
      wb(1'b1, 8'h1C, 32'h00);
      cpu(1'b0, 1'b1, 16'h01F0);
      cmp({stack_off_chip, select_line_n}, 9'h0FF);
      $display("select test done");
      @(posedge ref_clk);
      {reset_in_n, bus_enable_strap} <= 2'b01;
      repeat (6) @(posedge ref_clk);
      reset_in_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
      rd(8'h6C, 32'h00);
      @(negedge ref_clk);
      cmp(processor_external, 1'b0);
      $display("strap test done");
      report_and_stop;
   end
endmodule
